/* hdl/arpf_rx_formatter.sv */
// Asynchronous receive packet formatter: turns received packets and
// transmit confirmations into quadlet sequences for the receive queue.
// Assumes the bus front end strips CRC quadlets and flags data CRC and
// alignment at the last quadlet; all inputs are synchronous to CLOCK.
//
// Overview of operation
// [RULE1] Classify packets by transaction code into formats
// [RULE2] Self-ID/PHY data gets header with code E
// [RULE3] Transmit outcome becomes confirmation with code 8
// [RULE4] Destination ID bus and node parts kept
// [RULE5] Transaction label passed through unchanged
// [RULE6] Retry code field passed in two bits
// [RULE7] Priority field carried as received
// [RULE8] Source ID holds the sender's node ID
// [RULE9] Destination offset high and low delivered together
// [RULE10] Response code delivered in its field
// [RULE11] Single data quadlet placed in quadlet field
// [RULE12] Data length gives payload size in bytes
// [RULE13] Extended code delivered for lock operations
// [RULE14] Zero length block writes no data quadlets
// [RULE15] First payload byte in top byte
// [RULE16] Zero pad last quadlet of odd lengths
// [RULE17] Unsolicited bit set only for unsolicited responses
// [RULE18] Status holds acknowledge code returned to sender
// [RULE19] Unacknowledged packets still get would-be code
// [RULE20] First quadlet holds destination ID and header
// [RULE21] Every packet ends with reception status quadlet
// [RULE22] Complete is 0001, pending is 0010
// [RULE23] CRC or length failure gives code 1101; code gives it only for block packets and self-ID CRC failures
// [RULE24] Quadlets queued in order, never interleaved
`timescale 1ns/1ps

module arpf_rx_formatter
   import arpf_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   input  wire logic [31:0] RX_DATA,
   input  wire logic        RX_SOP,
   input  wire logic        RX_EOP,
   input  wire logic        RX_SELFID,
   input  wire logic [2:0]  RX_SPEED,
   input  wire logic        RX_DATA_OK,
   input  wire logic        RX_UNSOLICITED,
   input  wire logic [3:0]  HANDSHAKE_REPLY_CODE,
   input  wire logic        CONF_VALID,
   output logic             CONF_READY,
   input  wire logic [5:0]  CONF_TLABEL,
   input  wire logic [3:0]  CONF_STATUS,
   output logic             Q_VALID,
   output logic      [31:0] Q_DATA,
   input  wire logic        Q_READY
);

   arpf_reg_s   st_r;
   arpf_reg_s   st_nxt;
   logic        out_free;
   logic        rx_acc;
   logic        end_pkt;
   logic [3:0]  end_tc;
   logic [16:0] len_p3;
   logic [15:0] need_q;
   logic [15:0] rem_bytes;
   logic [2:0]  pad_n;
   logic [31:0] pad_data;

   function automatic arpf_fmt_e classify(input logic [3:0] tc);
      case (tc)
         `ARPF_TC_RD_QUAD_REQ,
         `ARPF_TC_WR_RESP:       classify = ARPF_FMT_NODATA;
         `ARPF_TC_WR_QUAD_REQ,
         `ARPF_TC_RD_QUAD_RESP,
         `ARPF_TC_RD_BLOCK_REQ:  classify = ARPF_FMT_QUAD;
         `ARPF_TC_WR_BLOCK_REQ,
         `ARPF_TC_RD_BLOCK_RESP,
         `ARPF_TC_LOCK_REQ,
         `ARPF_TC_LOCK_RESP:     classify = ARPF_FMT_BLOCK;
         // Unknown codes carry no payload we could frame safely
         default:                classify = ARPF_FMT_NODATA;
      endcase
   endfunction

   function automatic logic is_resp(input logic [3:0] tc);
      is_resp = (tc == `ARPF_TC_WR_RESP) || (tc == `ARPF_TC_RD_QUAD_RESP) ||
                (tc == `ARPF_TC_RD_BLOCK_RESP) ||
                (tc == `ARPF_TC_LOCK_RESP);
   endfunction

   function automatic logic [2:0] hdr_len(input arpf_fmt_e f);
      case (f)
         ARPF_FMT_QUAD:  hdr_len = `ARPF_HDR_QUAD;
         ARPF_FMT_BLOCK: hdr_len = `ARPF_HDR_BLOCK;
         default:        hdr_len = `ARPF_HDR_NODATA;
      endcase
   endfunction

   // Register stage drains freely or when the queue takes the word
   assign out_free   = !st_r.q_valid || Q_READY;
   assign RX_READY   = out_free &&
                       ((st_r.state == ARPF_ST_HDR) ||
                        (st_r.state == ARPF_ST_DATA) ||
                        (st_r.state == ARPF_ST_SID) ||
                        ((st_r.state == ARPF_ST_IDLE) && !RX_SELFID));
   // Confirmations wait for a gap so packets are never interleaved
   assign CONF_READY = out_free && (st_r.state == ARPF_ST_IDLE) &&
                       !RX_VALID;                              // [RULE24]
   assign rx_acc     = RX_VALID && RX_READY;
   assign Q_VALID    = st_r.q_valid;
   assign Q_DATA     = st_r.q_data;

   assign len_p3    = {1'b0, st_r.len} + 17'h0_0003;
   assign need_q    = {2'b00, len_p3[15:2]} | {1'b0, len_p3[16], 14'h0000};
   assign rem_bytes = st_r.len - {st_r.dcount[13:0], 2'b00};
   assign pad_n     = (rem_bytes >= 16'h0004) ? 3'h4 : rem_bytes[2:0];

   arpf_pad u_pad (
      .din    (RX_DATA),
      .nbytes (pad_n),
      .dout   (pad_data)
   );

   always_comb begin
      st_nxt         = st_r;
      end_pkt        = 1'b0;
      end_tc         = st_r.tcode;
      st_nxt.q_valid = st_r.q_valid && !Q_READY;
      case (st_r.state)
         ARPF_ST_IDLE: begin
            if (CONF_VALID && CONF_READY) begin
               st_nxt.q_valid = 1'b1;
               st_nxt.q_data  = {16'h0000, CONF_TLABEL, 2'b00,
                                 `ARPF_TC_CONFIRM, 4'h0};      // [RULE3]
               st_nxt.ack     = CONF_STATUS;
               st_nxt.u       = 1'b0;
               st_nxt.spd     = 3'h0;
               st_nxt.state   = ARPF_ST_STAT;
            end else if (RX_VALID && RX_SELFID && out_free) begin
               st_nxt.q_valid = 1'b1;
               st_nxt.q_data  = {24'h00_0000, `ARPF_TC_SELFID_PHY,
                                 4'h0};                        // [RULE2]
               st_nxt.fmt     = ARPF_FMT_SELF;
               st_nxt.tcode   = `ARPF_TC_SELFID_PHY;
               st_nxt.spd     = RX_SPEED;
               st_nxt.state   = ARPF_ST_SID;
            end else if (rx_acc && RX_SOP) begin
               // Header layout of the wire matches the queue layout
               st_nxt.q_valid = 1'b1;
               st_nxt.q_data  = RX_DATA;        // [RULE20] [RULE4] [RULE5]
               st_nxt.fmt     = classify(RX_DATA[`ARPF_TC_LSB +: 4]);
               st_nxt.tcode   = RX_DATA[`ARPF_TC_LSB +: 4];    // [RULE1]
               st_nxt.hcount  = 3'h1;
               st_nxt.dcount  = 16'h0000;
               st_nxt.len     = 16'h0000;
               st_nxt.mism    = 1'b0;
               st_nxt.spd     = RX_SPEED;
               st_nxt.state   = ARPF_ST_HDR;
               end_tc         = RX_DATA[`ARPF_TC_LSB +: 4];
               if (RX_EOP) begin
                  end_pkt     = 1'b1;
                  st_nxt.mism = (st_nxt.fmt == ARPF_FMT_BLOCK);
               end
            end
         end
         ARPF_ST_HDR: begin
            if (rx_acc) begin
               if (st_r.hcount < hdr_len(st_r.fmt)) begin
                  // Source ID, offsets, rCode, quadlet data, length and
                  // extended code all keep their received positions
                  st_nxt.q_valid = 1'b1;
                  st_nxt.q_data  = RX_DATA; // [RULE6] [RULE7] [RULE8] [RULE9]
                  st_nxt.hcount  = st_r.hcount + 3'h1; // [RULE10] [RULE11]
                  if ((st_r.fmt == ARPF_FMT_BLOCK) && (st_r.hcount == 3'h3))
                  begin
                     st_nxt.len   = RX_DATA[`ARPF_LEN_LSB +: 16]; // [RULE12]
                     st_nxt.state = ARPF_ST_DATA;             // [RULE13]
                  end
               end
               if (RX_EOP) begin
                  end_pkt     = 1'b1;
                  st_nxt.mism = (st_r.fmt == ARPF_FMT_BLOCK) &&
                                !((st_r.hcount == 3'h3) &&
                                  (RX_DATA[`ARPF_LEN_LSB +: 16] ==
                                   16'h0000));
               end
            end
         end
         ARPF_ST_DATA: begin
            if (rx_acc) begin
               if (st_r.dcount < need_q) begin
                  st_nxt.q_valid = 1'b1;
                  st_nxt.q_data  = pad_data;          // [RULE15] [RULE16]
                  st_nxt.dcount  = st_r.dcount + 16'h0001;
               end else begin
                  st_nxt.mism = 1'b1;                          // [RULE14]
               end
               if (RX_EOP) begin
                  end_pkt = 1'b1;
                  if (st_nxt.dcount != need_q) begin
                     st_nxt.mism = 1'b1;
                  end
               end
            end
         end
         ARPF_ST_SID: begin
            if (rx_acc) begin
               st_nxt.q_valid = 1'b1;
               st_nxt.q_data  = RX_DATA;
               end_pkt        = RX_EOP;
            end
         end
         ARPF_ST_STAT: begin
            if (out_free) begin
               st_nxt.q_valid = 1'b1;
               st_nxt.q_data  = {13'h0000, st_r.spd, st_r.u, 11'h000,
                                 st_r.ack};                    // [RULE21]
               st_nxt.state   = ARPF_ST_IDLE;
            end
         end
         default: begin
            st_nxt.state = ARPF_ST_IDLE;
         end
      endcase
      if (end_pkt) begin
         st_nxt.state = ARPF_ST_STAT;
         st_nxt.u     = RX_UNSOLICITED && is_resp(end_tc);     // [RULE17]
         if (st_r.fmt == ARPF_FMT_SELF && st_r.state == ARPF_ST_SID) begin
            st_nxt.ack = RX_DATA_OK ? `ARPF_ACK_COMPLETE
                                    : `ARPF_ACK_DATA_ERROR;   // [RULE22]
         end else if ((st_nxt.fmt == ARPF_FMT_BLOCK) &&
                      (st_nxt.mism || !RX_DATA_OK)) begin
            st_nxt.ack = `ARPF_ACK_DATA_ERROR;                 // [RULE23]
         end else begin
            // Broadcasts get the code the link would have returned
            st_nxt.ack = HANDSHAKE_REPLY_CODE;       // [RULE18] [RULE19]
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   sequence s_eop_taken;
      rx_acc && RX_EOP;
   endsequence

   sequence s_status_out;
      (st_r.state == ARPF_ST_STAT) && out_free;
   endsequence

   property p_hold_stall;
      @(posedge CLOCK) disable iff (!RST_N)
      (Q_VALID && !Q_READY) |=> (Q_VALID && $stable(Q_DATA));
   endproperty
   a_hold_stall: assert property (p_hold_stall) // [RULE24]
      else $error("Queue word changed while stalled");

   property p_classify_block;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.state == ARPF_ST_IDLE && rx_acc && RX_SOP && !RX_EOP &&
       RX_DATA[7:4] == `ARPF_TC_WR_BLOCK_REQ)
      |=> (st_r.fmt == ARPF_FMT_BLOCK);
   endproperty
   a_classify_block: assert property (p_classify_block) // [RULE1]
      else $error("Block write request not framed as block");

   property p_selfid_hdr;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.state == ARPF_ST_IDLE && RX_VALID && RX_SELFID && out_free &&
       !CONF_VALID)
      |=> (Q_VALID && Q_DATA[7:4] == `ARPF_TC_SELFID_PHY &&
           st_r.state == ARPF_ST_SID);
   endproperty
   a_selfid_hdr: assert property (p_selfid_hdr) // [RULE2]
      else $error("Self-ID header not synthesized");

   property p_confirm;
      @(posedge CLOCK) disable iff (!RST_N)
      (CONF_VALID && CONF_READY)
      |=> (Q_VALID && Q_DATA[7:4] == `ARPF_TC_CONFIRM &&
           Q_DATA[15:10] == $past(CONF_TLABEL) &&
           st_r.ack == $past(CONF_STATUS) &&
           st_r.state == ARPF_ST_STAT) ##[0:300] s_status_out;
   endproperty
   a_confirm: assert property (p_confirm) // [RULE3]
      else $error("Confirmation not framed with code 8 and status");

   property p_status_follows;
      @(posedge CLOCK) disable iff (!RST_N)
      s_eop_taken |=> (st_r.state == ARPF_ST_STAT) ##[0:300] s_status_out;
   endproperty
   a_status_follows: assert property (p_status_follows) // [RULE21]
      else $error("Last quadlet not followed by status");

   property p_status_word;
      @(posedge CLOCK) disable iff (!RST_N)
      s_status_out |=> (Q_VALID && Q_DATA[3:0] == $past(st_r.ack) &&
                        Q_DATA[`ARPF_STAT_U_BIT] == $past(st_r.u));
   endproperty
   a_status_word: assert property (p_status_word) // [RULE18]
      else $error("Status quadlet fields wrong");

   property p_data_error;
      @(posedge CLOCK) disable iff (!RST_N)
      (s_eop_taken and (st_r.state == ARPF_ST_DATA && !RX_DATA_OK))
      |=> (st_r.ack == `ARPF_ACK_DATA_ERROR);
   endproperty
   a_data_error: assert property (p_data_error) // [RULE23]
      else $error("Bad block data not flagged 1101");

   property p_solicited;
      @(posedge CLOCK) disable iff (!RST_N)
      (s_eop_taken and (st_r.state == ARPF_ST_HDR &&
                        !is_resp(st_r.tcode)))
      |=> !st_r.u;
   endproperty
   a_solicited: assert property (p_solicited) // [RULE17]
      else $error("Unsolicited bit set for a request");

   property p_zero_len;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.state == ARPF_ST_DATA && st_r.len == 16'h0000 && rx_acc)
      |=> !Q_VALID;
   endproperty
   a_zero_len: assert property (p_zero_len) // [RULE14]
      else $error("Data quadlet queued for zero length block");

   property p_pad;
      @(posedge CLOCK) disable iff (!RST_N)
      (st_r.state == ARPF_ST_DATA && rx_acc && rem_bytes == 16'h0001)
      |=> (Q_DATA[23:0] == 24'h00_0000);
   endproperty
   a_pad: assert property (p_pad) // [RULE16]
      else $error("Padding bytes not zero");

endmodule // arpf_rx_formatter

/* hdl/arpf_map.svh */
// Constants of the asynchronous receive packet formatter: transaction
// codes, acknowledge codes, field positions and header lengths.
// Assumes nothing; definitions only.
`ifndef ARPF_MAP_SVH
`define ARPF_MAP_SVH

// Transaction codes
`define ARPF_TC_WR_QUAD_REQ   4'h0
`define ARPF_TC_WR_BLOCK_REQ  4'h1
`define ARPF_TC_WR_RESP       4'h2
`define ARPF_TC_RD_QUAD_REQ   4'h4
`define ARPF_TC_RD_BLOCK_REQ  4'h5
`define ARPF_TC_RD_QUAD_RESP  4'h6
`define ARPF_TC_RD_BLOCK_RESP 4'h7
`define ARPF_TC_CONFIRM       4'h8
`define ARPF_TC_LOCK_REQ      4'h9
`define ARPF_TC_LOCK_RESP     4'hB
`define ARPF_TC_SELFID_PHY    4'hE

// Acknowledge codes
`define ARPF_ACK_COMPLETE     4'h1
`define ARPF_ACK_PENDING      4'h2
`define ARPF_ACK_DATA_ERROR   4'hD

// Field positions
`define ARPF_TC_LSB           4
`define ARPF_TL_LSB           10
`define ARPF_LEN_LSB          16
`define ARPF_STAT_SPD_LSB     16
`define ARPF_STAT_U_BIT       15

// Header quadlets passed to the queue per format
`define ARPF_HDR_NODATA       3'h3
`define ARPF_HDR_QUAD         3'h4
`define ARPF_HDR_BLOCK        3'h4

`endif

/* hdl/arpf_pkg.sv */
// Types of the asynchronous receive packet formatter.
// Assumes arpf_map.svh is on the include path.
`include "arpf_map.svh"

package arpf_pkg;

   typedef enum logic [2:0] {
      ARPF_ST_IDLE = 3'b000,
      ARPF_ST_HDR  = 3'b001,
      ARPF_ST_DATA = 3'b010,
      ARPF_ST_SID  = 3'b011,
      ARPF_ST_STAT = 3'b100
   } arpf_state_e;

   typedef enum logic [1:0] {
      ARPF_FMT_NODATA = 2'b00,
      ARPF_FMT_QUAD   = 2'b01,
      ARPF_FMT_BLOCK  = 2'b10,
      ARPF_FMT_SELF   = 2'b11
   } arpf_fmt_e;

   typedef struct packed {
      arpf_state_e state;
      arpf_fmt_e   fmt;
      logic [3:0]  tcode;
      logic [2:0]  hcount;
      logic [15:0] dcount;
      logic [15:0] len;
      logic        mism;
      logic [2:0]  spd;
      logic        u;
      logic [3:0]  ack;
      logic        q_valid;
      logic [31:0] q_data;
   } arpf_reg_s;

endpackage

/* hdl/arpf_pad.sv */
// Zero fill of the unused low bytes of a block data quadlet.
// Assumes the first payload byte already sits in bits 31:24.
`timescale 1ns/1ps

module arpf_pad
   import arpf_pkg::*;
(
   input  wire logic [31:0] din,
   input  wire logic [2:0]  nbytes,
   output logic      [31:0] dout
);

   always_comb begin
      case (nbytes)
         3'h1:    dout = {din[31:24], 24'h00_0000};
         3'h2:    dout = {din[31:16], 16'h0000};
         3'h3:    dout = {din[31:8], 8'h00};
         default: dout = din;
      endcase
   end

endmodule // arpf_pad

/* tb/arpf_phy_model.sv */
// Behavioural physical-layer partner that hands received packets to the
// formatter one quadlet at a time. Assumes inputs move on falling edges.
`timescale 1ns/1ps

module arpf_phy_model (
   input  wire logic        CLOCK,
   input  wire logic        RX_READY,
   output logic             RX_VALID,
   output logic      [31:0] RX_DATA,
   output logic             RX_SOP,
   output logic             RX_EOP,
   output logic             RX_SELFID,
   output logic      [2:0]  RX_SPEED,
   output logic             RX_DATA_OK,
   output logic             RX_UNSOLICITED,
   output logic      [3:0]  HANDSHAKE_REPLY_CODE
);
   logic took_r;

   // Captured before the edge's own updates land, so no race on RX_READY
   always @(posedge CLOCK) begin
      took_r <= RX_VALID && RX_READY;
   end

   initial begin
      {RX_VALID, RX_SOP, RX_EOP, RX_SELFID} = 4'h0;
      {RX_DATA, RX_SPEED, RX_DATA_OK, RX_UNSOLICITED} = '0;
      HANDSHAKE_REPLY_CODE = 4'h0;
   end

   // Gap gives idle cycles between quadlets, to act as a slow sender
   task automatic send(input logic [31:0] q[$], input logic sid,
                       input logic ok, input logic uns,
                       input logic [3:0] ack, input logic [2:0] spd,
                       input int gap);
      int n;
      @(negedge CLOCK);
      for (int i = 0; i < q.size(); i++) begin
         RX_VALID = 1'b1;
         RX_DATA = q[i];
         RX_SOP = (i == 0);
         RX_EOP = (i == q.size() - 1);
         RX_SELFID = sid;
         RX_SPEED = spd;
         RX_DATA_OK = ok;
         RX_UNSOLICITED = uns;
         HANDSHAKE_REPLY_CODE = ack;
         n = 0;
         do begin
            @(negedge CLOCK);
            n++;
         end while (!took_r && n < 300);
         if (gap > 0 || i == q.size() - 1) begin
            // A released line shows garbage, never the last value
            RX_VALID = 1'b0;
            RX_DATA = ~q[i];
            RX_SOP = 1'b0;
            RX_EOP = 1'b0;
            repeat (gap) @(negedge CLOCK);
         end
      end
      RX_SELFID = 1'b0;
      RX_DATA_OK = ~ok;
      RX_UNSOLICITED = ~uns;
      HANDSHAKE_REPLY_CODE = ~ack;
   endtask
endmodule // arpf_phy_model

/* tb/arpf_rx_formatter_tb.sv */
// Self-checking bench for the receive packet formatter.
// Assumes the physical-layer model and the design files are compiled.
`timescale 1ns/1ps

module arpf_rx_formatter_tb;
   import arpf_pkg::*;
   logic        CLOCK = 1'b0;
   logic        RST_N = 1'b0;
   logic        RX_VALID, RX_READY, RX_SOP, RX_EOP, RX_SELFID;
   logic [31:0] RX_DATA;
   logic [2:0]  RX_SPEED;
   logic        RX_DATA_OK, RX_UNSOLICITED;
   logic [3:0]  HANDSHAKE_REPLY_CODE;
   logic        CONF_VALID = 1'b0;
   logic        CONF_READY;
   logic [5:0]  CONF_TLABEL = 6'h00;
   logic [3:0]  CONF_STATUS = 4'h0;
   logic        Q_VALID;
   logic [31:0] Q_DATA;
   logic        Q_READY = 1'b1;
   logic        stall = 1'b0;
   logic        ctook;
   logic [31:0] got[$];
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cycles = 0;

   always #20 CLOCK = ~CLOCK;

   arpf_phy_model phy (.CLOCK(CLOCK), .RX_READY(RX_READY),
      .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_SOP(RX_SOP),
      .RX_EOP(RX_EOP), .RX_SELFID(RX_SELFID), .RX_SPEED(RX_SPEED),
      .RX_DATA_OK(RX_DATA_OK), .RX_UNSOLICITED(RX_UNSOLICITED),
      .HANDSHAKE_REPLY_CODE(HANDSHAKE_REPLY_CODE));

   arpf_rx_formatter dut (.CLOCK(CLOCK), .RST_N(RST_N),
      .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA),
      .RX_SOP(RX_SOP), .RX_EOP(RX_EOP), .RX_SELFID(RX_SELFID),
      .RX_SPEED(RX_SPEED), .RX_DATA_OK(RX_DATA_OK),
      .RX_UNSOLICITED(RX_UNSOLICITED),
      .HANDSHAKE_REPLY_CODE(HANDSHAKE_REPLY_CODE),
      .CONF_VALID(CONF_VALID), .CONF_READY(CONF_READY),
      .CONF_TLABEL(CONF_TLABEL), .CONF_STATUS(CONF_STATUS),
      .Q_VALID(Q_VALID), .Q_DATA(Q_DATA), .Q_READY(Q_READY));

   always @(posedge CLOCK) begin
      ctook <= CONF_VALID && CONF_READY;
      if (Q_VALID === 1'b1 && Q_READY === 1'b1) begin
         got.push_back(Q_DATA);
      end
   end

   // Stalling the queue exercises the refusal path on the bus side
   always @(negedge CLOCK) begin
      Q_READY <= stall ? ~Q_READY : 1'b1;
   end

   task automatic conclude();
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] h0(input logic [3:0] tc,
                                      input logic [1:0] rt);
      return {16'hFFFF, 6'h2D, rt, tc, 4'h0};
   endfunction

   function automatic logic [31:0] stat(input logic [2:0] spd,
                                        input logic u,
                                        input logic [3:0] ack);
      return {13'h0000, spd, u, 11'h000, ack};
   endfunction

   // Word 0 is compared under m0 only; the rest of the stream in full
   task automatic expect_q(input logic [31:0] e[$],
                           input logic [31:0] m0);
      int n;
      n = 0;
      while (got.size() < e.size() && n < 400) begin
         @(negedge CLOCK);
         n++;
      end
      repeat (4) @(negedge CLOCK);
      check("word count", 32'(got.size()), 32'(e.size()));
      foreach (e[i]) begin
         if (i < got.size())
            check("queue word", got[i] & (i == 0 ? m0 : '1),
                  e[i] & (i == 0 ? m0 : '1));
      end
      got.delete();
   endtask

   task automatic t_fmt();
      logic [3:0]  tc [5] = '{4'h4, 4'h2, 4'h0, 4'h6, 4'h5};
      logic [3:0]  ak [5] = '{4'h1, 4'h2, 4'h1, 4'h2, 4'h4};
      logic [31:0] q[$];
      logic [31:0] e[$];
      for (int i = 0; i < 5; i++) begin
         q = '{h0(tc[i], 2'(i)), 32'h0C45_7000, 32'h8000_0400};
         if (i >= 2) q.push_back(32'hA5C3_0F1E);
         e = q;
         e.push_back(stat(3'(i), tc[i] == 4'h2 || tc[i] == 4'h6, ak[i]));
         phy.send(q, 1'b0, 1'b1, 1'b1, ak[i], 3'(i), i % 2);
         expect_q(e, '1);
      end
   endtask

   task automatic t_block();
      logic [3:0]  tc [4] = '{4'h1, 4'h7, 4'h9, 4'hB};
      logic [15:0] ln [4] = '{16'h0000, 16'h0005, 16'h0008, 16'h0007};
      logic [31:0] q[$];
      logic [31:0] e[$];
      logic [31:0] w;
      int          nb;
      stall = 1'b1;
      for (int i = 0; i < 4; i++) begin
         q = '{h0(tc[i], 2'b01), 32'h0C45_7000, 32'h8000_0400,
               {ln[i], 16'(i)}};
         e = q;
         for (int k = 0; k < (ln[i] + 3) / 4; k++) begin
            w = 32'h1122_3344 + 32'(k);
            q.push_back(w);
            nb = ln[i] - 4 * k;
            e.push_back(nb >= 4 ? w : w & ~(32'hFFFF_FFFF >> (8 * nb)));
         end
         e.push_back(stat(3'h2, tc[i] == 4'h7 || tc[i] == 4'hB, 4'h1));
         phy.send(q, 1'b0, 1'b1, 1'b1, 4'h1, 3'h2, 0);
         expect_q(e, '1);
      end
      stall = 1'b0;
   endtask

   task automatic t_block_err();
      logic [31:0] q[$];
      logic [31:0] e[$];
      for (int i = 0; i < 3; i++) begin
         q = '{h0(4'h1, 2'b00), 32'h0C45_7000, 32'h8000_0400,
               {(i == 0 ? 16'h0008 : (i == 1 ? 16'h0004 : 16'h0000)),
                16'h0000}, 32'hDEAD_0001};
         e = q;
         // Zero length: the stray data quadlet must not reach the queue
         if (i == 2) void'(e.pop_back());
         e.push_back(stat(3'h1, 1'b0, 4'hD));
         phy.send(q, 1'b0, i != 1, 1'b0, 4'h1, 3'h1, 0);
         expect_q(e, '1);
      end
   endtask

   task automatic t_selfid();
      logic [31:0] q[$];
      logic [31:0] e[$];
      for (int i = 0; i < 2; i++) begin
         q = '{32'h8123_4567, 32'h7EDC_BA98, 32'h00FF_00FF};
         e = '{32'h0000_00E0};
         foreach (q[k]) e.push_back(q[k]);
         e.push_back(stat(3'h1, 1'b0, i == 0 ? 4'h1 : 4'hD));
         phy.send(q, 1'b1, i == 0, 1'b1, 4'h2, 3'h1, 1);
         expect_q(e, 32'h0000_00F0);
      end
   endtask

   task automatic t_confirm();
      logic [31:0] e[$];
      int          n;
      @(negedge CLOCK);
      CONF_VALID = 1'b1;
      CONF_TLABEL = 6'h2A;
      CONF_STATUS = 4'h5;
      n = 0;
      do begin
         @(negedge CLOCK);
         n++;
      end while (!ctook && n < 50);
      CONF_VALID = 1'b0;
      CONF_TLABEL = 6'h15;
      CONF_STATUS = 4'hA;
      e = '{{16'h0000, 6'h2A, 2'b00, 4'h8, 4'h0}, stat(3'h0, 1'b0, 4'h5)};
      expect_q(e, '1);
   endtask

   initial begin
      repeat (20) @(negedge CLOCK);
      check("idle valid", {31'h0, Q_VALID}, 32'h0000_0000);
      check("idle data", Q_DATA, 32'h0000_0000);
      RST_N = 1'b1;
      t_fmt();
      t_block();
      t_block_err();
      t_selfid();
      t_confirm();
      conclude();
   end
endmodule // arpf_rx_formatter_tb
